/* File: hdl/ascr_pkg.sv */
// Purpose: Shared constants and types for the AFE setup control register bank.
// Assumes: Registers are reached over the serial control interface only.
// Notes:   Field positions and reset values live here; ascr_top repeats the output reset values and the read-back bit packing.
package ascr_pkg;

    // ------------------------------------------------------------------
    // Register addresses (six-bit serial addresses)
    // ------------------------------------------------------------------
    localparam logic [5:0] ADDR_SETUP_ONE   = 6'h01;
    localparam logic [5:0] ADDR_SETUP_TWO   = 6'h02;
    localparam logic [5:0] ADDR_SETUP_THREE = 6'h03;
    localparam logic [5:0] ADDR_SOFT_RESET  = 6'h04;
    localparam logic [5:0] ADDR_CYCLE_RESET = 6'h05;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned POS_PGA_OFS   = 4;
    localparam int unsigned POS_FOURTH    = 6;
    localparam int unsigned POS_FORMAT    = 0;
    localparam int unsigned POS_INVERT    = 2;
    localparam int unsigned POS_REF_EXT   = 3;
    localparam int unsigned POS_DAC_RANGE = 5;
    localparam int unsigned POS_LATENCY   = 6;
    localparam int unsigned POS_CLAMP     = 0;
    localparam int unsigned POS_SAMPLE    = 4;
    localparam int unsigned POS_CHANNEL   = 6;

    // ------------------------------------------------------------------
    // Timing counts and serial framing
    // ------------------------------------------------------------------
    localparam logic [1:0] MCLK_PER_ADC_NORMAL = 2'h2;
    localparam logic [1:0] MCLK_PER_ADC_MODE3  = 2'h3;
    localparam int unsigned LATENCY_MAX_MCLK   = 9;
    localparam logic [4:0] FRAME_BITS          = 5'h10;
    localparam logic [4:0] HEADER_BITS         = 5'h08;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       fourth_mode_flag;
        logic [1:0] pga_output_offset_sel;
        logic [1:0] output_latency_sel;
        logic       clamp_dac_range;
        logic       clamp_ref_external;
        logic       output_invert;
        logic [1:0] output_format_sel;
        logic [1:0] mono_channel_sel;
        logic [1:0] reset_sample_adjust;
        logic [3:0] clamp_level_code;
    } ascr_cfg_t;

    localparam ascr_cfg_t CFG_RESET = '{
        fourth_mode_flag:      1'h0,
        pga_output_offset_sel: 2'h0,
        output_latency_sel:    2'h0,
        clamp_dac_range:       1'h1,
        clamp_ref_external:    1'h0,
        output_invert:         1'h0,
        output_format_sel:     2'h0,
        mono_channel_sel:      2'h0,
        reset_sample_adjust:   2'h1,
        clamp_level_code:      4'hf
    };

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] data;
    } ascr_wr_t;

    typedef enum logic [1:0] {
        PGA_ZERO    = 2'h0,
        PGA_POS_FS  = 2'h1,
        PGA_NEG_FS  = 2'h2
    } ascr_pga_t;

    typedef enum logic [1:0] {
        COL_RED   = 2'h0,
        COL_GREEN = 2'h1,
        COL_BLUE  = 2'h2
    } ascr_colour_t;

    typedef enum logic [1:0] {
        SER_IDLE  = 2'b01,
        SER_SHIFT = 2'b10
    } ascr_ser_t;

endpackage : ascr_pkg

/* File: hdl/ascr_serial.sv */
// Purpose: Serial control port slave: 16-bit frames, write and read-back.
// Assumes: Pins are asynchronous to clock and far slower than it.
// Notes:   Frame is {read, 0, addr[5:0], data[7:0]}, MSB first, sampled on rising sclk.
`timescale 1ns/1ns
`default_nettype none
module ascr_serial
    import ascr_pkg::*;
(
    input  wire logic       clock,     // Master clock.
    input  wire logic       rst_n,     // Synchronised reset.
    input  wire logic       ser_clk,   // Serial clock pin.
    input  wire logic       ser_din,   // Serial data pin.
    input  wire logic       ser_en_n,  // Frame enable pin, low in a frame.
    input  wire logic [7:0] rd_data,   // Read-back for hdr_addr.
    output logic      [5:0] hdr_addr,  // Address of the current frame.
    output ascr_wr_t        wr,        // Completed write.
    output logic            wr_pulse,  // One-cycle write strobe.
    output logic            ser_dout   // Read data pin.
);

    logic [2:0]  sync1_r, sync2_r, sync3_r;
    ascr_ser_t   state_r, state_nxt;
    logic [4:0]  cnt_r;
    logic [15:0] shift_r;
    logic [7:0]  dout_r;
    logic        load_r;
    logic        rd_r;

    // Only sync2 and sync3 feed logic; sync1 is the metastability stage.
    wire sclk_rise = sync2_r[2] & ~sync3_r[2];
    wire sen_rise  = sync2_r[0] & ~sync3_r[0];
    wire in_frame  = ~sync2_r[0];
    wire hdr_done  = (state_r == SER_SHIFT) & sclk_rise & (cnt_r == HEADER_BITS - 5'h01);
    wire frame_ok  = (cnt_r == FRAME_BITS) & ~shift_r[15];

    assign hdr_addr = shift_r[5:0];

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SER_IDLE:  if (in_frame) state_nxt = SER_SHIFT;
            SER_SHIFT: if (sen_rise) state_nxt = SER_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 3'h7;
            sync2_r <= 3'h7;
            sync3_r <= 3'h7;
        end else begin
            sync1_r <= {ser_clk, ser_din, ser_en_n};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= SER_IDLE;
            cnt_r    <= 5'h00;
            shift_r  <= 16'h0000;
            rd_r     <= 1'h0;
        end else begin
            state_r <= state_nxt;
            if (state_r == SER_IDLE) begin
                cnt_r <= 5'h00;
            end else if (sclk_rise && cnt_r != FRAME_BITS) begin
                cnt_r   <= cnt_r + 5'h01;
                shift_r <= {shift_r[14:0], sync2_r[1]};
            end
            if (hdr_done) rd_r <= shift_r[6];
        end
    end

    // Read data is fetched one cycle after the header lands so hdr_addr is settled.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            load_r   <= 1'h0;
            dout_r   <= 8'h00;
            ser_dout <= 1'h0;
            wr       <= '0;
            wr_pulse <= 1'h0;
        end else begin
            load_r <= hdr_done;
            if (load_r && rd_r) begin
                dout_r   <= {rd_data[6:0], 1'h0};
                ser_dout <= rd_data[7];
            end else if (sclk_rise && cnt_r > HEADER_BITS) begin
                dout_r   <= {dout_r[6:0], 1'h0};
                ser_dout <= dout_r[7];
            end
            wr_pulse <= (state_r == SER_SHIFT) & sen_rise & frame_ok;
            if ((state_r == SER_SHIFT) && sen_rise && frame_ok) begin
                wr <= '{addr: shift_r[13:8], data: shift_r[7:0]};
            end
        end
    end

endmodule : ascr_serial
`default_nettype wire

/* File: hdl/ascr_delay.sv */
// Purpose: Programmable-tap delay line for the output word and its valid.
// Assumes: Tap count is stable while data flows.
// Notes:   Tap 0 is a plain register stage, so the line always adds one cycle.
`timescale 1ns/1ns
`default_nettype none
module ascr_delay
    import ascr_pkg::*;
#(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = LATENCY_MAX_MCLK
) (
    input  wire logic             clock,   // Master clock.
    input  wire logic             rst_n,   // Synchronised reset.
    input  wire logic [WIDTH-1:0] din,     // Word in.
    input  wire logic             vin,     // Valid in.
    input  wire logic [3:0]       taps,    // Extra cycles of delay.
    output logic      [WIDTH-1:0] dout,    // Delayed word.
    output logic                  vout     // Delayed valid.
);

    initial begin
        if (DEPTH < 1 || DEPTH > 15 || WIDTH < 1) $error("ascr_delay: bad size");
    end

    logic [WIDTH:0] line_r [DEPTH+1];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i <= DEPTH; i++) line_r[i] <= '0;
        end else begin
            line_r[0] <= {vin, din};
            for (int i = 1; i <= DEPTH; i++) line_r[i] <= line_r[i-1];
        end
    end

    wire [WIDTH:0] tap_w = (taps > 4'(DEPTH)) ? line_r[DEPTH] : line_r[taps];

    assign dout = tap_w[WIDTH-1:0];
    assign vout = tap_w[WIDTH];

endmodule : ascr_delay
`default_nettype wire

/* File: hdl/ascr_top.sv */
// Purpose: AFE setup control register bank with output polarity, latency and format logic.
// Assumes: Timing logic on the same clock supplies mode, phase and colour-advance inputs.
// Notes:   Clock is the master clock; one ADC period is two or three of its cycles.
// What this block does
// - PGA offset code gives zero, +FS, -FS.
// - Fourth-mode flag set only in fourth mode; the block stores the written bit without checking the mode.
// - Format code selects 16, 8+8, 4x4 output.
// - Invert bit digitally inverts output data.
// - External reference bit powers clamp DAC down.
// - Range bit picks clamp DAC span.
// - Latency field adds zero to three ADC periods.
// - ADC period is two MCLK, three in mode three.
// - Four-bit code sets clamp DAC level.
// - Reset sample shifts -1, 0, +1, +2 MCLK.
// - Mono channel code picks red, green, blue.
// - Soft reset write resets all cells.
// - Cycle reset write returns colour to red.
// - Line-sequential select: 0 normal, 1 line mode.
`timescale 1ns/1ns
`default_nettype none
module ascr_top
    import ascr_pkg::*;
#(
    parameter int unsigned DATA_W = 16
) (
    input  wire logic              clock,                  // Master clock, 50 MHz.
    input  wire logic              arst_n,                 // Asynchronous reset, low active.
    input  wire logic              ser_clk,                // Serial clock pin.
    input  wire logic              ser_din,                // Serial data pin.
    input  wire logic              ser_en_n,               // Serial frame enable pin.
    output logic                   ser_dout,               // Serial read data pin.
    input  wire logic [DATA_W-1:0] adc_word,               // Converted word.
    input  wire logic              adc_valid,              // Word strobe.
    input  wire logic              mode_three,             // Third operating mode active.
    input  wire logic [1:0]        out_phase,              // Byte or nibble slot.
    input  wire logic              line_sequential_enable, // Line mode select.
    input  wire logic              colour_advance,         // Auto-cycle step pulse.
    output logic      [DATA_W-1:0] out_data,               // Formatted output bus.
    output logic                   out_valid,              // Output word valid.
    output logic                   fourth_mode_flag,       // Fourth-mode flag.
    output ascr_pga_t              pga_offset_action,      // PGA output offset.
    output logic                   clamp_dac_power_down,   // Clamp DAC off.
    output logic                   clamp_dac_range,        // Clamp DAC span select.
    output logic      [3:0]        clamp_level_code,       // Clamp DAC code.
    output logic signed [2:0]      reset_sample_shift,     // Reset sample shift, MCLK.
    output logic      [1:0]        output_format_sel,      // Output format code.
    output ascr_colour_t           mono_channel,           // Routed mono channel.
    output ascr_colour_t           cycle_colour,           // Auto-cycle colour.
    output logic                   cell_reset              // All-cell reset pulse.
);

    initial begin
        if (DATA_W != 16) $error("ascr_top: output formats need a 16-bit word");
    end

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_r;
    wire        rst_n = rst_sync_r[1];

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'h1};
        end
    end

    // ------------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------------
    ascr_wr_t   wr;
    logic       wr_pulse;
    logic [5:0] hdr_addr;
    logic [7:0] rd_data;

    ascr_serial u_serial (
        .clock    (clock),
        .rst_n    (rst_n),
        .ser_clk  (ser_clk),
        .ser_din  (ser_din),
        .ser_en_n (ser_en_n),
        .rd_data  (rd_data),
        .hdr_addr (hdr_addr),
        .wr       (wr),
        .wr_pulse (wr_pulse),
        .ser_dout (ser_dout)
    );

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    ascr_cfg_t cfg_r, cfg_nxt;

    wire wr_one   = wr_pulse & (wr.addr == ADDR_SETUP_ONE);
    wire wr_two   = wr_pulse & (wr.addr == ADDR_SETUP_TWO);
    wire wr_three = wr_pulse & (wr.addr == ADDR_SETUP_THREE);
    wire soft_hit = wr_pulse & (wr.addr == ADDR_SOFT_RESET);
    wire cyc_hit  = wr_pulse & (wr.addr == ADDR_CYCLE_RESET);

    // Reserved channel code 11 is refused so the router never sees it.
    wire chan_ok = wr.data[POS_CHANNEL+:2] != 2'h3;

    always_comb begin
        cfg_nxt = cfg_r;
        if (wr_one) begin
            cfg_nxt.fourth_mode_flag      = wr.data[POS_FOURTH];
            cfg_nxt.pga_output_offset_sel = wr.data[POS_PGA_OFS+:2];
        end
        if (wr_two) begin
            cfg_nxt.output_format_sel  = wr.data[POS_FORMAT+:2];
            cfg_nxt.output_invert      = wr.data[POS_INVERT];
            cfg_nxt.clamp_ref_external = wr.data[POS_REF_EXT];
            cfg_nxt.clamp_dac_range    = wr.data[POS_DAC_RANGE];
            cfg_nxt.output_latency_sel = wr.data[POS_LATENCY+:2];
        end
        if (wr_three) begin
            cfg_nxt.clamp_level_code    = wr.data[POS_CLAMP+:4];
            cfg_nxt.reset_sample_adjust = wr.data[POS_SAMPLE+:2];
            if (chan_ok) cfg_nxt.mono_channel_sel = wr.data[POS_CHANNEL+:2];
        end
        if (soft_hit) cfg_nxt = CFG_RESET;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= CFG_RESET;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // Strobe addresses and anything unmapped read back as zero.
    assign rd_data = (hdr_addr == ADDR_SETUP_ONE) ?
                         {1'h0, cfg_r.fourth_mode_flag, cfg_r.pga_output_offset_sel, 4'h0} :
                     (hdr_addr == ADDR_SETUP_TWO) ?
                         {cfg_r.output_latency_sel, cfg_r.clamp_dac_range, 1'h0,
                          cfg_r.clamp_ref_external, cfg_r.output_invert, cfg_r.output_format_sel} :
                     (hdr_addr == ADDR_SETUP_THREE) ?
                         {cfg_r.mono_channel_sel, cfg_r.reset_sample_adjust, cfg_r.clamp_level_code} :
                     8'h00;

    // ------------------------------------------------------------------
    // Analogue control decode
    // ------------------------------------------------------------------
    ascr_pga_t    pga_w;
    logic [2:0]   shift_w;
    ascr_colour_t chan_w;

    always_comb begin
        unique case (cfg_r.pga_output_offset_sel)
            2'h2:    pga_w = PGA_POS_FS;
            2'h3:    pga_w = PGA_NEG_FS;
            default: pga_w = PGA_ZERO;
        endcase
    end

    always_comb begin
        unique case (cfg_r.reset_sample_adjust)
            2'h0:    shift_w = 3'h7;
            2'h1:    shift_w = 3'h0;
            2'h2:    shift_w = 3'h1;
            default: shift_w = 3'h2;
        endcase
    end

    // Line mode forces the red channel so internal timing stays consistent.
    always_comb begin
        if (line_sequential_enable) begin
            chan_w = COL_RED;
        end else begin
            unique case (cfg_r.mono_channel_sel)
                2'h1:    chan_w = COL_GREEN;
                2'h2:    chan_w = COL_BLUE;
                default: chan_w = COL_RED;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Colour auto-cycle counter
    // ------------------------------------------------------------------
    ascr_colour_t colour_r, colour_nxt;

    always_comb begin
        colour_nxt = colour_r;
        if (colour_advance && line_sequential_enable) begin
            unique case (colour_r)
                COL_RED:   colour_nxt = COL_GREEN;
                COL_GREEN: colour_nxt = COL_BLUE;
                default:   colour_nxt = COL_RED;
            endcase
        end
        // A reset write outranks a step that lands in the same cycle.
        if (cyc_hit || soft_hit) colour_nxt = COL_RED;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            colour_r <= COL_RED;
        end else begin
            colour_r <= colour_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Output polarity and latency
    // ------------------------------------------------------------------
    wire [1:0] adc_period = mode_three ? MCLK_PER_ADC_MODE3 : MCLK_PER_ADC_NORMAL;
    wire [3:0] lat_mclk   = 4'(cfg_r.output_latency_sel * adc_period);
    wire [DATA_W-1:0] pol_word = adc_word ^ {DATA_W{cfg_r.output_invert}};

    logic [DATA_W-1:0] dly_word;
    logic              dly_valid;

    ascr_delay #(
        .WIDTH (DATA_W),
        .DEPTH (LATENCY_MAX_MCLK)
    ) u_delay (
        .clock (clock),
        .rst_n (rst_n),
        .din   (pol_word),
        .vin   (adc_valid),
        .taps  (lat_mclk),
        .dout  (dly_word),
        .vout  (dly_valid)
    );

    // ------------------------------------------------------------------
    // Output format
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] fmt_w;

    always_comb begin
        unique case (cfg_r.output_format_sel)
            2'h0:    fmt_w = dly_word;
            2'h3:    fmt_w = {12'h000, dly_word[4*(3-out_phase)+:4]};
            default: fmt_w = {8'h00, out_phase[0] ? dly_word[7:0] : dly_word[15:8]};
        endcase
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_data             <= '0;
            out_valid            <= 1'h0;
            fourth_mode_flag     <= 1'h0;
            pga_offset_action    <= PGA_ZERO;
            clamp_dac_power_down <= 1'h0;
            clamp_dac_range      <= 1'h1;
            clamp_level_code     <= 4'hf;
            reset_sample_shift   <= 3'h0;
            output_format_sel    <= 2'h0;
            mono_channel         <= COL_RED;
            cycle_colour         <= COL_RED;
            cell_reset           <= 1'h0;
        end else begin
            out_data             <= fmt_w;
            out_valid            <= dly_valid;
            fourth_mode_flag     <= cfg_r.fourth_mode_flag;
            pga_offset_action    <= pga_w;
            clamp_dac_power_down <= cfg_r.clamp_ref_external;
            clamp_dac_range      <= cfg_r.clamp_dac_range;
            clamp_level_code     <= cfg_r.clamp_level_code;
            reset_sample_shift   <= shift_w;
            output_format_sel    <= cfg_r.output_format_sel;
            mono_channel         <= chan_w;
            cycle_colour         <= colour_r;
            cell_reset           <= soft_hit;
        end
    end

endmodule : ascr_top
`default_nettype wire

/* File: tb/ascr_top_sva.sv */
// Purpose: Port-level checks of the setup register bank.
// Assumes: Bound to ascr_top; sees its ports only.
// Notes:   Register contents are judged by the outputs they drive.
`timescale 1ns/1ns
`default_nettype none
module ascr_top_sva
    import ascr_pkg::*;
(
    input wire logic              clock,                  // Clock.
    input wire logic              arst_n,                 // Reset.
    input wire logic              line_sequential_enable, // Line mode.
    input wire logic              colour_advance,         // Step.
    input wire ascr_pga_t         pga_offset_action,      // Offset.
    input wire logic              clamp_dac_range,        // Span.
    input wire logic [3:0]        clamp_level_code,       // Level.
    input wire logic signed [2:0] reset_sample_shift,     // Shift.
    input wire ascr_colour_t      mono_channel,           // Channel.
    input wire ascr_colour_t      cycle_colour,           // Colour.
    input wire logic              cell_reset              // Pulse.
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    AST_PULSE: assert property (cell_reset |=> !cell_reset[*4])
        else $error("cell reset too long");
    AST_SOFT: assert property (cell_reset |-> ##[0:2] (clamp_level_code == 4'hf && clamp_dac_range
        && pga_offset_action == PGA_ZERO && reset_sample_shift == 3'sh0)) else $error("soft reset left state");
    AST_PGA: assert property (pga_offset_action != 2'h3)
        else $error("bad offset action");
    AST_SHIFT: assert property (reset_sample_shift inside {3'h7, 3'h0, 3'h1, 3'h2})
        else $error("bad sample shift");
    AST_MONO: assert property (mono_channel != 2'h3)
        else $error("reserved channel");
    AST_LINE: assert property (line_sequential_enable[*3] |-> mono_channel == COL_RED)
        else $error("line mode not red");
    AST_STEP: assert property (line_sequential_enable && colour_advance && cycle_colour == COL_RED
        |=> ##1 cycle_colour == COL_GREEN) else $error("colour did not step");
    AST_BOOT: assert property ($rose(arst_n) |-> (clamp_level_code == 4'hf && clamp_dac_range)[*2])
        else $error("bad reset defaults");
    cover property (cell_reset);
    cover property (line_sequential_enable && colour_advance);
    cover property (mono_channel == COL_BLUE);
endmodule : ascr_top_sva
`default_nettype wire

/* File: tb/ascr_ctrl_model.sv */
// Purpose: Scanner controller model on the serial control port.
// Assumes: Acts on falling clock edges; half sets each sclk level.
// Notes:   Sclk stands low between frames; a released data line flips.
`timescale 1ns/1ns
`default_nettype none
module ascr_ctrl_model (
    input  wire logic clock,    // Master clock.
    input  wire logic ser_dout, // Read data.
    output logic      ser_clk,  // Serial clock.
    output logic      ser_din,  // Serial data.
    output logic      ser_en_n  // Frame enable.
);
    int half = 5;
    initial begin
        ser_clk = 1'b0;
        ser_din = 1'b0;
        ser_en_n = 1'b1;
    end
    task automatic frame(input logic rd, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [15:0] w;
        w = {rd, 1'b0, a, d};
        q = 8'h00;
        ser_en_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            ser_din = w[i];
            repeat (half) @(negedge clock);
            ser_clk = 1'b1;
            repeat (half) @(negedge clock);
            if (i < 8) q = {q[6:0], ser_dout};
            ser_clk = 1'b0;
        end
        repeat (half) @(negedge clock);
        ser_en_n = 1'b1;
        ser_din = ~ser_din;
        repeat (10) @(negedge clock);
    endtask : frame
endmodule : ascr_ctrl_model
`default_nettype wire

/* File: tb/afe_setup_control_registers_tb.sv */
// Purpose: Self-checking bench for the setup register bank.
// Assumes: The model drives the serial port; the bench drives the rest.
// Notes:   adc_word stays fixed so every output slot is known.
`timescale 1ns/1ns
`default_nettype none
module afe_setup_control_registers_tb;
    import ascr_pkg::*;
    logic clock = 1'b0, arst_n = 1'b0, adc_valid = 1'b0, mode_three = 1'b0;
    logic line_sequential_enable = 1'b0, colour_advance = 1'b0;
    logic [1:0] out_phase = 2'h0;
    logic [15:0] adc_word = 16'h5a3c;
    logic ser_clk, ser_din, ser_en_n, ser_dout, out_valid, fourth_mode_flag, clamp_dac_power_down;
    logic clamp_dac_range, cell_reset;
    logic [15:0] out_data;
    logic [3:0] clamp_level_code;
    logic signed [2:0] reset_sample_shift;
    logic [1:0] output_format_sel;
    ascr_pga_t pga_offset_action;
    ascr_colour_t mono_channel, cycle_colour;
    logic [3:0] ftab [4] = '{4'h4, 4'h9, 4'hd, 4'hf};
    logic [15:0] fexp [4] = '{16'h005a, 16'h003c, 16'h000a, 16'h000c};
    int miscompares = 0, n_tests = 0, pulses = 0, cnt;
    ascr_top u_ascr_top (.*);
    ascr_ctrl_model u_ascr_ctrl_model (.*);
    initial forever #10 clock = ~clock;
    always @(posedge clock) if (cell_reset === 1'b1) pulses++;
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] x;
        u_ascr_ctrl_model.frame(1'b0, a, d, x);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] x;
        u_ascr_ctrl_model.frame(1'b1, a, 8'h00, x);
        chk({8'h00, x}, {8'h00, e});
    endtask : rd
    task automatic send();
        adc_valid = 1'b1;
        @(negedge clock) adc_valid = 1'b0;
        cnt = 1;
        while (out_valid !== 1'b1 && cnt < 40) begin
            @(negedge clock);
            cnt++;
        end
    endtask : send
    task automatic adv();
        colour_advance = 1'b1;
        @(negedge clock) colour_advance = 1'b0;
        @(negedge clock);
    endtask : adv
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (10) @(negedge clock);
        arst_n = 1'b1;
        repeat (6) @(negedge clock);
        chk({clamp_dac_range, clamp_level_code, fourth_mode_flag}, 16'h3e);
        chk({pga_offset_action, reset_sample_shift, output_format_sel, mono_channel}, 16'h0);
        wr(ADDR_SOFT_RESET, 8'h00);
        rd(ADDR_SETUP_TWO, 8'h20);
        $display("test 1 done");
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_SETUP_ONE, {1'b0, c[0], c[1:0], 4'h0});
            chk(pga_offset_action, c < 2 ? 0 : c - 1);
            chk(fourth_mode_flag, c[0]);
            rd(ADDR_SETUP_ONE, {1'b0, c[0], c[1:0], 4'h0});
        end
        $display("test 2 done");
        u_ascr_ctrl_model.half = 9;
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_SETUP_THREE, {c[1:0], c[1:0], 4'h5 + c[3:0]});
            chk(reset_sample_shift, c - 1);
            chk(mono_channel, c == 3 ? 2 : c);
            rd(ADDR_SETUP_THREE, {c == 3 ? 2'h2 : c[1:0], c[1:0], 4'h5 + c[3:0]});
        end
        u_ascr_ctrl_model.half = 5;
        wr(ADDR_SETUP_TWO, 8'h1f);
        chk({clamp_dac_power_down, clamp_dac_range}, 16'h2);
        $display("test 3 done");
        for (int l = 0; l < 4; l++) begin
            for (int m = 0; m < 2; m++) begin
                mode_three = m[0];
                wr(ADDR_SETUP_TWO, {l[1:0], 6'h24});
                send();
                chk(cnt, 2 + l * (m + 2));
                chk(out_data, ~adc_word);
            end
        end
        for (int i = 0; i < 4; i++) begin
            out_phase = ftab[i][1:0];
            wr(ADDR_SETUP_TWO, {6'h08, ftab[i][3:2]});
            send();
            chk(out_data, fexp[i]);
            chk(output_format_sel, ftab[i][3:2]);
        end
        $display("test 4 done");
        line_sequential_enable = 1'b1;
        repeat (3) @(negedge clock);
        chk(mono_channel, COL_RED);
        adv();
        adv();
        chk(cycle_colour, COL_BLUE);
        wr(ADDR_CYCLE_RESET, 8'ha5);
        chk(cycle_colour, COL_RED);
        adv();
        cnt = pulses;
        wr(ADDR_SOFT_RESET, 8'hff);
        chk(pulses, cnt + 1);
        chk({cycle_colour, clamp_level_code}, 16'h0f);
        rd(ADDR_SETUP_THREE, 8'h1f);
        rd(ADDR_SOFT_RESET, 8'h00);
        $display("test 5 done");
        wrap_up();
    end
    initial begin
        #1_000_000;
        miscompares++;
        wrap_up();
    end
endmodule : afe_setup_control_registers_tb
bind ascr_top ascr_top_sva u_ascr_top_sva (.*);
`default_nettype wire
